// File: rtl/supervisor_pkg.sv
package supervisor_pkg;

    // Clock period in picoseconds (250 MHz).
    localparam int CLK_PERIOD_PS = 4000;

    // Push-button glitch rejection, ns, and least low time, us.
    localparam int BUTTON_GLITCH_NS = 100;
    localparam int BUTTON_MIN_LOW_US = 1;
    localparam int BUTTON_MIN_LOW_CYCLES =
        (BUTTON_MIN_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Shortest strobe pulse that must be seen, ns.
    localparam int STROBE_MIN_PULSE_NS = 50;
    localparam int STROBE_MIN_PULSE_CYCLES =
        (STROBE_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Reset hold period and watchdog timeout, in ms.
    localparam int RESET_HOLD_MS = 140;
    localparam int WATCHDOG_TIMEOUT_MS = 1600;
    localparam longint RESET_HOLD_CYCLES_DEF =
        (64'(RESET_HOLD_MS) * 1000000000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam longint WATCHDOG_TIMEOUT_CYCLES_DEF =
        (64'(WATCHDOG_TIMEOUT_MS) * 1000000000) / CLK_PERIOD_PS;

    // Undervoltage dip rejection length, cycles (8 us).
    localparam int SUPPLY_GLITCH_US = 8;
    localparam int SUPPLY_GLITCH_CYCLES =
        (SUPPLY_GLITCH_US * 1000000) / CLK_PERIOD_PS;

    // Reset value of synchronised pins (idle levels).
    localparam logic PIN_IDLE_HIGH = 1'b1;
    localparam logic PIN_IDLE_LOW = 1'b0;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_HOLD,
        ST_RUN
    } supervisor_state_type;

    typedef struct packed {
        logic under_voltage;
        logic button_low;
        logic strobe_edge;
        logic strobe_valid;
    } cause_type;

    typedef struct packed {
        logic reset_n;
        logic reset;
    } reset_out_type;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
    import supervisor_pkg::*;
#(
    parameter logic INIT = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic change_o
);

    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic level_reg;
    logic level_next;

    // Stage 0 feeds only stage 1; a change counts when stages 1 and 2 agree.
    always_comb begin
        stage_next = {stage_reg[1:0], pin_i};
        level_next = level_reg;
        if (stage_reg[2] == stage_reg[1]) begin
            level_next = stage_reg[2];
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage_reg <= {3{INIT}};
            level_reg <= INIT;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;
    assign change_o = level_next != level_reg;

endmodule

// File: rtl/low_filter.sv
`timescale 1ns/10ps
module low_filter
    import supervisor_pkg::*;
#(
    parameter int LEN = 4
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic active_i,
    output logic qualified_o
);

    localparam int W = $clog2(LEN + 1);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic qual_reg;
    logic qual_next;

    // Assert only after LEN + 1 consecutive active cycles; release at once.
    always_comb begin
        count_next = count_reg;
        qual_next = qual_reg;
        if (!active_i) begin
            count_next = '0;
            qual_next = 1'b0;
        end else if (count_reg < W'(LEN)) begin
            count_next = count_reg + W'(1);
        end else begin
            qual_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_reg <= '0;
            qual_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            qual_reg <= qual_next;
        end
    end

    assign qualified_o = qual_reg;

endmodule

// File: rtl/supply_supervisor_watchdog_reset.sv
`timescale 1ns/10ps
module supply_supervisor_watchdog_reset
    import supervisor_pkg::*;
#(
    parameter longint RESET_HOLD_CYCLES = RESET_HOLD_CYCLES_DEF,
    parameter longint WATCHDOG_TIMEOUT_CYCLES = WATCHDOG_TIMEOUT_CYCLES_DEF,
    parameter int SUPPLY_FILTER_CYCLES = SUPPLY_GLITCH_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic under_voltage_i,
    input wire logic push_button_reset_n_i,
    input wire logic push_button_driven_i,
    input wire logic watchdog_strobe_in_i,
    input wire logic watchdog_strobe_driven_i,
    output logic reset_n_o,
    output logic reset_o,
    output logic watchdog_expired_o
);

    localparam int CW = 32;

    cause_type cause;
    reset_out_type rst_out;
    supervisor_state_type state_reg;
    supervisor_state_type state_next;
    logic [CW-1:0] hold_reg;
    logic [CW-1:0] hold_next;
    logic [CW-1:0] wd_reg;
    logic [CW-1:0] wd_next;
    logic expire_reg;
    logic expire_next;
    logic uv_sync;
    logic btn_sync;
    logic btn_drv_sync;
    logic strobe_sync;
    logic strobe_drv_sync;
    logic btn_low_raw;
    logic uv_qual;
    logic btn_qual;
    logic strobe_change;
    logic hw_cause;
    logic wd_fire;

    function automatic logic [CW-1:0] last_count(input longint n);
        last_count = CW'(n - 1);
    endfunction

    // All pins enter through three-stage synchronisers.
    pin_sync #(.INIT(PIN_IDLE_LOW)) u_uv (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(under_voltage_i),
        .level_o(uv_sync),
        .change_o()
    );
    pin_sync #(.INIT(PIN_IDLE_HIGH)) u_btn (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(push_button_reset_n_i),
        .level_o(btn_sync),
        .change_o()
    );
    pin_sync #(.INIT(PIN_IDLE_LOW)) u_btn_drv (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(push_button_driven_i),
        .level_o(btn_drv_sync),
        .change_o()
    );
    pin_sync #(.INIT(PIN_IDLE_LOW)) u_strobe (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(watchdog_strobe_in_i),
        .level_o(strobe_sync),
        .change_o(strobe_change)
    );
    pin_sync #(.INIT(PIN_IDLE_LOW)) u_strobe_drv (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(watchdog_strobe_driven_i),
        .level_o(strobe_drv_sync),
        .change_o()
    );

    // An undriven button pin is masked by its driven flag, so it never requests reset.
    assign btn_low_raw = btn_drv_sync & ~btn_sync;

    // Short button lows are dropped; a low longer than 1 us (251 cycles) qualifies a press.
    low_filter #(.LEN(BUTTON_MIN_LOW_CYCLES)) u_btn_filt (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .active_i(btn_low_raw),
        .qualified_o(btn_qual)
    );

    // Supply dips shorter than the rejection length are ignored.
    low_filter #(.LEN(SUPPLY_FILTER_CYCLES)) u_uv_filt (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .active_i(uv_sync),
        .qualified_o(uv_qual)
    );

    always_comb begin
        cause.under_voltage = uv_qual;
        cause.button_low = btn_qual;
        cause.strobe_edge = strobe_change;
        cause.strobe_valid = strobe_drv_sync;
    end

    assign hw_cause = cause.under_voltage | cause.button_low;
    assign wd_fire = cause.strobe_valid && state_reg == ST_RUN
        && wd_reg == last_count(WATCHDOG_TIMEOUT_CYCLES);

    // Reset sequencer: assert on any cause, then hold for the hold period.
    always_comb begin
        state_next = state_reg;
        hold_next = hold_reg;
        unique case (state_reg)
            ST_RESET: begin
                hold_next = '0;
                if (!hw_cause) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hw_cause) begin
                    state_next = ST_RESET;
                end else if (hold_reg == last_count(RESET_HOLD_CYCLES)) begin
                    state_next = ST_RUN;
                end else begin
                    hold_next = hold_reg + CW'(1);
                end
            end
            ST_RUN: begin
                hold_next = '0;
                if (hw_cause) begin
                    state_next = ST_RESET;
                end else if (wd_fire) begin
                    state_next = ST_HOLD;
                end
            end
        endcase
    end

    // Watchdog counter: cleared by either strobe edge and held in reset.
    always_comb begin
        wd_next = wd_reg + CW'(1);
        expire_next = wd_fire;
        if (state_reg != ST_RUN || hw_cause) begin
            wd_next = '0;
        end else if (cause.strobe_edge || !cause.strobe_valid) begin
            wd_next = '0;
        end else if (wd_fire) begin
            wd_next = '0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_RESET;
            hold_reg <= '0;
            wd_reg <= '0;
            expire_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            wd_reg <= wd_next;
            expire_reg <= expire_next;
        end
    end

    always_comb begin
        rst_out.reset = state_reg != ST_RUN;
        rst_out.reset_n = ~rst_out.reset;
    end

    assign reset_o = rst_out.reset;
    assign reset_n_o = rst_out.reset_n;
    assign watchdog_expired_o = expire_reg;

    // Assertions.
    int unsigned hold_seen;
    int unsigned btn_low_run;

    // Counts consecutive cycles of a synchronised button low.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            btn_low_run <= 0;
        end else if (btn_low_raw) begin
            btn_low_run <= btn_low_run + 1;
        end else begin
            btn_low_run <= 0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_seen <= 0;
        end else if (state_reg == ST_HOLD) begin
            hold_seen <= hold_seen + 1;
        end else begin
            hold_seen <= 0;
        end
    end

    property p_outputs_complement;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        reset_o != reset_n_o;
    endproperty
    a_outputs_complement: assert property (p_outputs_complement)
        else $error("reset outputs not complementary");

    property p_cause_resets;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        hw_cause |=> reset_o;
    endproperty
    a_cause_resets: assert property (p_cause_resets)
        else $error("cause did not assert reset");

    property p_button_resets;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        btn_qual |=> reset_o && state_reg == ST_RESET;
    endproperty
    a_button_resets: assert property (p_button_resets)
        else $error("button low did not hold reset");

    property p_full_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state_reg == ST_HOLD && state_next == ST_RUN)
        |-> hold_seen == RESET_HOLD_CYCLES - 1;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("reset released before hold period");

    property p_wd_clear_in_reset;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        reset_o |=> wd_reg == 0;
    endproperty
    a_wd_clear_in_reset: assert property (p_wd_clear_in_reset)
        else $error("watchdog counted during reset");

    property p_strobe_clears;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        strobe_change |=> wd_reg == 0;
    endproperty
    a_strobe_clears: assert property (p_strobe_clears)
        else $error("strobe edge did not clear watchdog");

    property p_expiry_holds;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wd_fire && !hw_cause |=> state_reg == ST_HOLD && reset_o;
    endproperty
    a_expiry_holds: assert property (p_expiry_holds)
        else $error("watchdog expiry did not reset");

    property p_float_no_expiry;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !strobe_drv_sync |-> !wd_fire ##1 !watchdog_expired_o;
    endproperty
    a_float_no_expiry: assert property (p_float_no_expiry)
        else $error("floating strobe fired watchdog");

    property p_short_low_ignored;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        btn_low_raw && btn_low_run < BUTTON_MIN_LOW_CYCLES |-> !btn_qual;
    endproperty
    a_short_low_ignored: assert property (p_short_low_ignored)
        else $error("short button glitch qualified");

    c_wd_fire: cover property (@(posedge sys_clk_i) wd_fire);
    c_button: cover property (@(posedge sys_clk_i) $rose(btn_qual));
    c_release: cover property (@(posedge sys_clk_i) $fell(reset_o));
    c_uv: cover property (@(posedge sys_clk_i) $rose(uv_qual));

endmodule

// File: sim/host_model.sv
`timescale 1ns/10ps
module host_model
    import supervisor_pkg::*;
#(
    parameter int PERIOD = 40
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic drive_i,
    output logic strobe_o,
    output logic driven_o
);
    int count;

    initial begin
        strobe_o = 1'b0;
        count = 0;
    end

    assign driven_o = drive_i;

    // A driving host held in reset does not run code, so it cannot strobe.
    always @(posedge sys_clk_i) begin
        if (!drive_i) begin
            strobe_o <= ~strobe_o;
        end else if (reset_n_i !== 1'b1 || !enable_i) begin
            strobe_o <= 1'b0;
            count <= 0;
        end else begin
            count <= (count == PERIOD - 1) ? 0 : count + 1;
            strobe_o <= (count < STROBE_MIN_PULSE_CYCLES);
        end
    end
endmodule

// File: sim/supply_supervisor_watchdog_reset_test.sv
`timescale 1ns/10ps
module supply_supervisor_watchdog_reset_test;
    import supervisor_pkg::*;
    localparam int HOLD = 20;
    localparam int TMO = 50;
    logic sys_clk_i, sys_rst_i, under_voltage, button_n, button_driven;
    logic host_enable, host_drive, strobe, strobe_driven;
    logic reset_n, reset, expired;
    int errors, samples_checked;

    supply_supervisor_watchdog_reset #(
        .RESET_HOLD_CYCLES(HOLD),
        .WATCHDOG_TIMEOUT_CYCLES(TMO),
        .SUPPLY_FILTER_CYCLES(4)
    ) i_dut (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .under_voltage_i(under_voltage),
        .push_button_reset_n_i(button_n),
        .push_button_driven_i(button_driven),
        .watchdog_strobe_in_i(strobe),
        .watchdog_strobe_driven_i(strobe_driven),
        .reset_n_o(reset_n),
        .reset_o(reset),
        .watchdog_expired_o(expired)
    );

    host_model i_host (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n),
        .enable_i(host_enable),
        .drive_i(host_drive),
        .strobe_o(strobe),
        .driven_o(strobe_driven)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_value(string name, logic [31:0] seen,
                               logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, seen);
        end
    endtask

    task automatic watch(int n, output int resets, output int pulses);
        resets = 0;
        pulses = 0;
        repeat (n) begin
            @(posedge sys_clk_i);
            if (reset !== 1'b0) resets++;
            if (expired !== 1'b0) pulses++;
            check_value("reset pair", reset_n, !reset);
        end
    endtask

    task automatic wait_reset(logic val, int bound, output int n);
        n = 0;
        while (reset !== val) begin
            @(posedge sys_clk_i);
            n++;
            if (n > bound) begin
                check_value("reset wait", reset, val);
                stop_test();
            end
        end
    endtask

    task automatic test_power_up();
        int n;
        repeat (6) @(posedge sys_clk_i);
        check_value("reset in sys reset", reset, 1'b1);
        check_value("reset_n in sys reset", reset_n, 1'b0);
        check_value("pulse in sys reset", expired, 1'b0);
        sys_rst_i <= 1'b0;
        wait_reset(1'b0, HOLD + 30, n);
        check_value("power-up hold", n >= HOLD && n <= HOLD + 10, 1);
        $display("test power_up done");
    endtask

    task automatic test_keep_alive();
        int r, p;
        watch(300, r, p);
        check_value("alive resets", r, 0);
        check_value("alive pulses", p, 0);
        $display("test keep_alive done");
    endtask

    task automatic test_float_strobe();
        int r, p;
        host_drive <= 1'b0;
        watch(300, r, p);
        check_value("float resets", r, 0);
        check_value("float pulses", p, 0);
        host_drive <= 1'b1;
        $display("test float_strobe done");
    endtask

    task automatic test_watchdog();
        int n;
        wait_reset(1'b0, 10, n);
        n = 0;
        while (!(strobe === 1'b0 && i_host.count == STROBE_MIN_PULSE_CYCLES + 1)
               && n < 100) begin
            @(posedge sys_clk_i);
            n++;
        end
        check_value("strobe phase", n < 100, 1);
        host_enable <= 1'b0;
        n = 0;
        while (expired !== 1'b1 && n < TMO + 30) begin
            @(posedge sys_clk_i);
            n++;
        end
        check_value("expiry time", n >= TMO && n <= TMO + 8, 1);
        check_value("reset on expiry", reset, 1'b1);
        check_value("reset_n on expiry", reset_n, 1'b0);
        host_enable <= 1'b1;
        wait_reset(1'b0, HOLD + 20, n);
        check_value("expiry hold", n >= HOLD - 1 && n <= HOLD + 4, 1);
        $display("test watchdog done");
    endtask

    task automatic test_button();
        int r, p, n;
        int lens[2] = '{25, 240};
        foreach (lens[i]) begin
            button_n <= 1'b0;
            repeat (lens[i]) @(posedge sys_clk_i);
            button_n <= 1'b1;
            watch(30, r, p);
            check_value("short press", r, 0);
        end
        // A floating pin carries no meaning, so its level is set low here.
        button_driven <= 1'b0;
        button_n <= 1'b0;
        watch(300, r, p);
        check_value("button floating", r, 0);
        button_driven <= 1'b1;
        wait_reset(1'b1, 280, n);
        check_value("press delay", n >= 250 && n <= 262, 1);
        watch(200, r, p);
        check_value("press holds reset", r, 200);
        check_value("no expiry in reset", p, 0);
        button_n <= 1'b1;
        wait_reset(1'b0, HOLD + 20, n);
        check_value("press hold", n >= HOLD && n <= HOLD + 8, 1);
        $display("test button done");
    endtask

    task automatic test_supply();
        int r, p, n;
        under_voltage <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        under_voltage <= 1'b0;
        watch(40, r, p);
        check_value("short dip", r, 0);
        under_voltage <= 1'b1;
        wait_reset(1'b1, 15, n);
        watch(80, r, p);
        check_value("dip holds reset", r, 80);
        check_value("no expiry in dip", p, 0);
        under_voltage <= 1'b0;
        wait_reset(1'b0, HOLD + 20, n);
        check_value("dip hold", n >= HOLD && n <= HOLD + 8, 1);
        $display("test supply done");
    endtask

    initial begin
        errors = 0;
        samples_checked = 0;
        sys_rst_i = 1'b1;
        under_voltage = 1'b0;
        button_n = 1'b1;
        button_driven = 1'b1;
        host_enable = 1'b1;
        host_drive = 1'b1;
        test_power_up();
        test_keep_alive();
        test_float_strobe();
        test_watchdog();
        test_button();
        test_supply();
        test_keep_alive();
        stop_test();
    end
endmodule
